// ### src/pcpc_core.sv
// Purpose: Clock division, keyed power control, lock fault and supply status
// Assumes: PLL output, lock and supply levels arrive asynchronously
// Notes: Clock outputs are regenerated at 200 MHz; edges jitter by one cycle
//
// Strobed register access is this design's own decision.
`timescale 1ns/10ps
`include "pcpc_defs.svh"

module pcpc_core #(
    parameter int DIV_W = 3
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // Register port
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    // Analog and pin status
    input wire logic i_pll_clk,
    input wire logic i_pll_locked,
    input wire logic i_rx_pin,
    input wire logic i_supply_main,
    input wire logic i_main_ok,
    // Power sequencer
    input wire pcpc_pkg::pcpc_mode_t i_mode,
    // Outputs
    output pcpc_pkg::pcpc_clk_t o_clk,
    output pcpc_pkg::pcpc_ctl_t o_ctl,
    output logic o_mcu_reset,
    output logic o_wake_req,
    output logic o_rtc_wr,
    output logic o_irq
);

    // ======================================================
    // Helpers
    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction

    // ======================================================
    // Synchronisers: stage one feeds only stage two
    localparam int NSYNC = 5;
    // Reset to each pin's idle level: locked high, main supply high.
    // A zero here would fake a lock fault and a supply change after reset.
    localparam logic [NSYNC-1:0] SYNC_IDLE = 5'h12;
    logic [NSYNC-1:0] async_in;
    logic [NSYNC-1:0] sync1_q;
    logic [NSYNC-1:0] sync2_q;
    logic [NSYNC-1:0] prev_q;
    assign async_in = {i_supply_main, i_main_ok, i_rx_pin, i_pll_locked, i_pll_clk};

    genvar g;
    generate
        for (g = 0; g < NSYNC; g++) begin : g_sync
            always_ff @(posedge i_clk or negedge i_rst_n) begin
                if (!i_rst_n) begin
                    sync1_q[g] <= SYNC_IDLE[g];
                    sync2_q[g] <= SYNC_IDLE[g];
                    prev_q[g] <= SYNC_IDLE[g];
                end else begin
                    sync1_q[g] <= async_in[g];
                    sync2_q[g] <= sync1_q[g];
                    prev_q[g] <= sync2_q[g];
                end
            end
        end
    endgenerate

    wire pll_clk_s = sync2_q[0];
    wire locked_s = sync2_q[1];
    wire rx_s = sync2_q[2];
    wire ok_s = sync2_q[3];
    wire main_s = sync2_q[4];
    wire half_evt = pll_clk_s ^ prev_q[0];
    wire lock_lost = prev_q[1] & ~locked_s;
    wire rx_edge = rx_s ^ prev_q[2];
    wire src_change = main_s ^ prev_q[4];

    // ======================================================
    // Registers
    logic [7:0] key_q;
    logic pw_unlock_q;
    logic rtc_unlock_q;
    logic [DIV_W-1:0] div_q;
    logic meter_off_q;
    logic core_off_q;
    logic wake_flag_q;
    logic src_q;
    logic fault_q;
    logic extref_q;
    pcpc_pkg::pcpc_rx_t rxf_q;
    logic [`PCPC_IRQ_BITS-1:0] irq_stat_q;
    logic [`PCPC_IRQ_BITS-1:0] irq_mask_q;

    // ======================================================
    // Write decode
    wire wr_key = i_wr & hit(i_addr, `PCPC_OFF_KEY);
    wire wr_pw = i_wr & hit(i_addr, `PCPC_OFF_POWER) & pw_unlock_q;
    wire wr_adc = i_wr & hit(i_addr, `PCPC_OFF_ADC_START);
    wire wr_per = i_wr & hit(i_addr, `PCPC_OFF_PERIPHERAL_SUPPLY_CONFIG);
    wire wr_ist = i_wr & hit(i_addr, `PCPC_OFF_IRQ_STAT);
    wire wr_imk = i_wr & hit(i_addr, `PCPC_OFF_IRQ_MASK);
    wire wr_rtc = i_wr & (i_addr >= `PCPC_OFF_RTC_LO) & (i_addr <= `PCPC_OFF_RTC_HI);
    wire fault_ack = wr_adc & i_wdata[`PCPC_AS_ACK];
    wire wake_clr = wr_per & i_wdata[`PCPC_PR_WAKE];
    wire wake_set = (i_mode == pcpc_pkg::PCPC_MODE_SLEEP) & (rxf_q == pcpc_pkg::PCPC_RX_WAKE)
        & rx_edge;

    // ======================================================
    // Key register: a key write of 0xA7 or 0xEA arms exactly one following write
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            key_q <= 8'h00;
            pw_unlock_q <= 1'b0;
            rtc_unlock_q <= 1'b0;
        end else if (wr_key) begin
            key_q <= i_wdata;
            pw_unlock_q <= (i_wdata == `PCPC_KEY_POWER);
            rtc_unlock_q <= (i_wdata == `PCPC_KEY_RTC);
        end else if (i_wr) begin
            pw_unlock_q <= 1'b0;
            rtc_unlock_q <= 1'b0;
        end
    end

    // ======================================================
    // Power control register
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            div_q <= DIV_W'(`PCPC_RST_DIV);
            meter_off_q <= 1'b0;
            core_off_q <= 1'b0;
        end else if (wr_pw) begin
            div_q <= i_wdata[`PCPC_PW_DIV_HI:0];
            meter_off_q <= i_wdata[`PCPC_PW_METER_OFF];
            core_off_q <= i_wdata[`PCPC_PW_CORE_OFF];
        end
    end

    // ======================================================
    // Peripheral configuration and status
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wake_flag_q <= 1'b0;
            src_q <= 1'b1;
            fault_q <= 1'b0;
            extref_q <= 1'b0;
            rxf_q <= pcpc_pkg::PCPC_RX_GPIO;
        end else begin
            src_q <= main_s;
            if (wake_set) begin
                wake_flag_q <= 1'b1;
            end else if (wake_clr) begin
                wake_flag_q <= 1'b0;
            end
            // Set wins: an unlocked PLL keeps the flag high
            if (!locked_s) begin
                fault_q <= 1'b1;
            end else if (fault_ack) begin
                fault_q <= 1'b0;
            end
            if (wr_per) begin
                extref_q <= i_wdata[`PCPC_PR_EXTREF];
                rxf_q <= pcpc_pkg::pcpc_rx_t'(i_wdata[1:0]);
            end
        end
    end

    // ======================================================
    // Interrupt status, write one to clear, set wins
    wire [`PCPC_IRQ_BITS-1:0] irq_evt = {src_change, wake_set, lock_lost};
    generate
        for (g = 0; g < `PCPC_IRQ_BITS; g++) begin : g_irq
            always_ff @(posedge i_clk or negedge i_rst_n) begin
                if (!i_rst_n) begin
                    irq_stat_q[g] <= 1'b0;
                end else if (irq_evt[g]) begin
                    irq_stat_q[g] <= 1'b1;
                end else if (wr_ist & i_wdata[g]) begin
                    irq_stat_q[g] <= 1'b0;
                end
            end
        end
    endgenerate

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            irq_mask_q <= '0;
        end else if (wr_imk) begin
            irq_mask_q <= i_wdata[`PCPC_IRQ_BITS-1:0];
        end
    end

    // ======================================================
    // Read mux
    wire [7:0] pw_rd = {1'b0, meter_off_q, 1'b0, core_off_q, 1'b0, div_q};
    wire [7:0] per_rd = {wake_flag_q, src_q, ok_s, fault_q, 1'b0, extref_q, rxf_q};
    wire [7:0] rd_mux =
        hit(i_addr, `PCPC_OFF_KEY) ? key_q :
        hit(i_addr, `PCPC_OFF_POWER) ? pw_rd :
        hit(i_addr, `PCPC_OFF_PERIPHERAL_SUPPLY_CONFIG) ? per_rd :
        hit(i_addr, `PCPC_OFF_IRQ_STAT) ? {5'h00, irq_stat_q} :
        hit(i_addr, `PCPC_OFF_IRQ_MASK) ? {5'h00, irq_mask_q} : 8'h00;

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_rdata <= 8'h00;
        end else begin
            o_rdata <= i_rd ? rd_mux : 8'h00;
        end
    end

    // ======================================================
    // Clock regeneration; counts run in half periods of the PLL clock
    // so that divider code 000 still yields the full system rate
    logic [6:0] core_cnt_q;
    logic [2:0] meter_cnt_q;
    wire [6:0] core_lim = 7'((8'h01 << div_q) - 8'h01);
    wire core_wrap = half_evt & (core_cnt_q >= core_lim);
    wire meter_wrap = half_evt & (meter_cnt_q == 3'(`PCPC_METER_DIV - 1));

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            core_cnt_q <= 7'h00;
            meter_cnt_q <= 3'h0;
            o_clk <= '0;
        end else begin
            o_clk.sys <= pll_clk_s & locked_s;
            if (core_wrap) begin
                core_cnt_q <= 7'h00;
                o_clk.core <= ~o_clk.core;
            end else if (half_evt) begin
                core_cnt_q <= core_cnt_q + 7'h01;
            end
            if (meter_wrap) begin
                meter_cnt_q <= 3'h0;
                o_clk.meter <= ~o_clk.meter;
            end else if (half_evt) begin
                meter_cnt_q <= meter_cnt_q + 3'h1;
            end
        end
    end

    // ======================================================
    // Outputs
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_ctl <= '{1'b0, 1'b0, 1'b0, pcpc_pkg::PCPC_RX_GPIO};
            o_mcu_reset <= 1'b0;
            o_wake_req <= 1'b0;
            o_rtc_wr <= 1'b0;
            o_irq <= 1'b0;
        end else begin
            o_ctl.meter_off <= meter_off_q & (i_mode == pcpc_pkg::PCPC_MODE_NORMAL);
            o_ctl.core_shutdown <= core_off_q & (i_mode == pcpc_pkg::PCPC_MODE_BATTERY);
            o_ctl.ext_ref <= extref_q;
            o_ctl.rx_func <= rxf_q;
            o_mcu_reset <= lock_lost;
            o_wake_req <= wake_set;
            o_rtc_wr <= wr_rtc & rtc_unlock_q;
            o_irq <= |(irq_stat_q & irq_mask_q);
        end
    end

endmodule // pcpc_core

// ### src/pcpc_defs.svh
// Purpose: Offsets, field positions, reset values and timing for the clock and power block
// Assumes: 8-bit register port, 200 MHz block clock
// Notes: Included by the core module and the testbench
// Function
// - Regenerate 4.096 MHz system clock from locked PLL
// - Core clock is system clock over 2^divider
// - Divider resets to code 010, 1.024 MHz
// - Metering clock is system over five, always
// - Key 0xA7 must precede power control write
// - Key 0xEA unlocks one timekeeping register write
// - Lock loss resets MCU, sets fault flag
// - Software acknowledge clears the lock fault flag
// - Bit 6 stops metering in normal mode
// - Bit 4 stops core in battery mode
// - Receive edge wake-up from sleep sets flag
// - Bit 6 reports supply source, resets to 1
// - Bit 5 reports main supply acceptable
// - Receive pin function field selects pin use
// - Writing 1 to start bit 7 clears fault
`ifndef PCPC_DEFS_SVH
`define PCPC_DEFS_SVH

// ==========================================================
// Register offsets
`define PCPC_OFF_KEY 8'hC1
`define PCPC_OFF_POWER 8'hC5
`define PCPC_OFF_ADC_START 8'hD8
`define PCPC_OFF_PERIPHERAL_SUPPLY_CONFIG 8'hF4
`define PCPC_OFF_IRQ_STAT 8'hE8
`define PCPC_OFF_IRQ_MASK 8'hE9
`define PCPC_OFF_RTC_LO 8'hA2
`define PCPC_OFF_RTC_HI 8'hA5

// ==========================================================
// Key values
`define PCPC_KEY_POWER 8'hA7
`define PCPC_KEY_RTC 8'hEA

// ==========================================================
// Field positions
`define PCPC_PW_METER_OFF 6
`define PCPC_PW_CORE_OFF 4
`define PCPC_PW_DIV_HI 2
`define PCPC_PR_WAKE 7
`define PCPC_PR_SRC 6
`define PCPC_PR_OK 5
`define PCPC_PR_FAULT 4
`define PCPC_PR_EXTREF 2
`define PCPC_AS_ACK 7
`define PCPC_IRQ_LOCK 0
`define PCPC_IRQ_WAKE 1
`define PCPC_IRQ_SRC 2

// ==========================================================
// Reset values and masks
`define PCPC_RST_DIV 3'h2
`define PCPC_POWER_MASK 8'h57
`define PCPC_IRQ_BITS 3

// ==========================================================
// Timing: metering clock is system clock over five
`define PCPC_METER_DIV 5

`endif

// ### src/pcpc_pkg.sv
// Purpose: Types shared by the clock and power block
// Assumes: Nothing beyond the defs header
// Notes: Constants live in the defs header
package pcpc_pkg;

    // ======================================================
    // Operating modes, driven by the power sequencer
    typedef enum logic [1:0] {
        PCPC_MODE_NORMAL = 2'b00,
        PCPC_MODE_BATTERY = 2'b01,
        PCPC_MODE_SLEEP = 2'b10
    } pcpc_mode_t;

    // ======================================================
    // Receive pin function
    typedef enum logic [1:0] {
        PCPC_RX_GPIO = 2'b00,
        PCPC_RX_NOWAKE = 2'b01,
        PCPC_RX_RSVD = 2'b10,
        PCPC_RX_WAKE = 2'b11
    } pcpc_rx_t;

    // ======================================================
    // Regenerated clocks
    typedef struct packed {
        logic sys;
        logic core;
        logic meter;
    } pcpc_clk_t;

    // ======================================================
    // Power control outputs
    typedef struct packed {
        logic meter_off;
        logic core_shutdown;
        logic ext_ref;
        pcpc_rx_t rx_func;
    } pcpc_ctl_t;

endpackage

// ### sim/pcpc_pll_model.sv
// Purpose: Crystal and PLL stand-in for the clock and power block
// Assumes: Lock loss is commanded by the bench
// Notes: Output freezes while unlocked, as a stalled loop would
`timescale 1ns/10ps
module pcpc_pll_model (
    // Command
    input wire logic i_lose_lock,
    // PLL side
    output logic o_pll_clk,
    output logic o_locked
);
    // ==========================================
    // 4.096 MHz is 125 times the 32.768 kHz crystal
    initial begin
        o_pll_clk = 1'b0;
        forever begin
            #122.07;
            if (!i_lose_lock) begin
                o_pll_clk = ~o_pll_clk;
            end
        end
    end
    assign o_locked = !i_lose_lock;
endmodule // pcpc_pll_model

// ### sim/pcpc_core_chk.sv
// Purpose: Port checks for the clock and power block
// Assumes: One clock domain, async active-low reset
// Notes: Bound from the bench top
`timescale 1ns/10ps
module pcpc_core_chk (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // Register port
    input wire logic [7:0] i_addr,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [7:0] o_rdata,
    // Status and outputs
    input wire logic i_pll_locked,
    input wire pcpc_pkg::pcpc_mode_t i_mode,
    input wire pcpc_pkg::pcpc_ctl_t o_ctl,
    input wire logic o_mcu_reset,
    input wire logic o_wake_req,
    input wire logic o_rtc_wr
);
    // ==========================================
    // Assertions
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    a_adc_reads_zero: assert property ($past(i_rd) && $past(i_addr) == 8'hD8 |-> o_rdata == 8'h00)
        else $error("start register read not zero");
    a_reset_pulse: assert property (o_mcu_reset |=> !o_mcu_reset)
        else $error("mcu reset longer than one cycle");
    a_lock_to_reset: assert property ($fell(i_pll_locked) |-> ##3 o_mcu_reset)
        else $error("no mcu reset after lock loss");
    a_wake_pulse: assert property (o_wake_req |=> !o_wake_req)
        else $error("wake request longer than one cycle");
    a_wake_func: assert property (o_wake_req |-> o_ctl.rx_func == pcpc_pkg::PCPC_RX_WAKE)
        else $error("wake without wake function");
    a_meter_mode: assert property (o_ctl.meter_off |-> $past(i_mode) == pcpc_pkg::PCPC_MODE_NORMAL)
        else $error("meter off outside normal mode");
    a_core_mode: assert property (o_ctl.core_shutdown |-> $past(i_mode) == pcpc_pkg::PCPC_MODE_BATTERY)
        else $error("core off outside battery mode");
    a_rtc_after_write: assert property (o_rtc_wr |-> $past(i_wr) && $past(i_addr) inside {[8'hA2:8'hA5]})
        else $error("rtc write pulse without write");
endmodule // pcpc_core_chk

// ### sim/testbench.sv
// Purpose: Self-checking bench for the clock and power block
// Assumes: PLL model drives the PLL clock and lock inputs; the bench drives the 200 MHz block clock
// Notes: Ratios are counted in regenerated edges, so sync jitter cancels
`timescale 1ns/10ps
`include "pcpc_defs.svh"
module testbench;
    logic i_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic [7:0] i_addr = 8'h00;
    logic [7:0] i_wdata = 8'h00;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic i_rx_pin = 1'b0;
    logic i_supply_main = 1'b1;
    logic i_main_ok = 1'b0;
    logic lose = 1'b0;
    pcpc_pkg::pcpc_mode_t i_mode = pcpc_pkg::PCPC_MODE_NORMAL;
    logic [7:0] o_rdata;
    logic pll_clk, locked, o_mcu_reset, o_wake_req, o_rtc_wr, o_irq;
    pcpc_pkg::pcpc_clk_t o_clk;
    pcpc_pkg::pcpc_ctl_t o_ctl;
    int err_total = 0;
    int checks = 0;
    int n_rst = 0, n_wake = 0, n_rtc = 0, n;
    logic [31:0] rnd = 32'hE7C03C03;
    logic [7:0] v;
    pcpc_pll_model pcpc_pll_model_i (.i_lose_lock(lose), .o_pll_clk(pll_clk), .o_locked(locked));
    pcpc_core pcpc_core_i (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_pll_clk(pll_clk), .i_pll_locked(locked),
        .i_rx_pin(i_rx_pin), .i_supply_main(i_supply_main), .i_main_ok(i_main_ok), .i_mode(i_mode),
        .o_clk(o_clk), .o_ctl(o_ctl), .o_mcu_reset(o_mcu_reset), .o_wake_req(o_wake_req),
        .o_rtc_wr(o_rtc_wr), .o_irq(o_irq));
    initial begin
        forever #2.5 i_clk = ~i_clk;
    end
    always @(posedge i_clk) begin
        n_rst <= n_rst + (o_mcu_reset === 1'b1);
        n_wake <= n_wake + (o_wake_req === 1'b1);
        n_rtc <= n_rtc + (o_rtc_wr === 1'b1);
    end
    // ==========================================
    // Helpers
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [7:0] exp_pow(input logic [7:0] w);
        return w & `PCPC_POWER_MASK;
    endfunction
    task automatic cmp(input logic [7:0] g, input logic [7:0] e);
        checks++;
        if (g !== e) begin
            err_total++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask
    task automatic kwr(input logic [7:0] k, input logic [7:0] a, input logic [7:0] d);
        wr(`PCPC_OFF_KEY, k);
        wr(a, d);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        @(posedge i_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1 cmp(o_rdata, e);
    endtask
    task automatic wt(input int k);
        repeat (k) @(posedge i_clk);
        #1;
    endtask
    // Sys rises within one period of core (sel 0) or meter (sel 1)
    task automatic ratio(input int sel, output int r);
        int k, e;
        logic p, ps, c;
        r = 0;
        e = 0;
        p = 1'b1;
        ps = 1'b1;
        for (k = 0; k < 20000 && e < 2; k++) begin
            wt(1);
            c = sel ? o_clk.meter : o_clk.core;
            if (e == 1 && o_clk.sys && !ps) r++;
            if (c && !p) e++;
            p = c;
            ps = o_clk.sys;
        end
    endtask
    task automatic summarize();
        $display("checks=%0d err_total=%0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // ==========================================
    // Tests
    initial begin
        #400000;
        err_total++;
        summarize();
    end
    initial begin
        wt(5);
        i_rst_n <= 1'b1;
        wt(4);
        rdc(`PCPC_OFF_POWER, 8'h02);
        rdc(`PCPC_OFF_PERIPHERAL_SUPPLY_CONFIG, 8'h40);
        rdc(`PCPC_OFF_KEY, 8'h00);
        rdc(8'h10, 8'h00);
        i_supply_main <= 1'b0;
        i_main_ok <= 1'b1;
        wt(3);
        rdc(`PCPC_OFF_PERIPHERAL_SUPPLY_CONFIG, 8'h20);
        i_supply_main <= 1'b1;
        $display("test reset done");
        wr(`PCPC_OFF_POWER, 8'h07);
        rdc(`PCPC_OFF_POWER, 8'h02);
        kwr(8'h5A, `PCPC_OFF_POWER, 8'h07);
        rdc(`PCPC_OFF_POWER, 8'h02);
        kwr(`PCPC_KEY_POWER, `PCPC_OFF_POWER, 8'hFF);
        rdc(`PCPC_OFF_POWER, exp_pow(8'hFF));
        wr(`PCPC_OFF_KEY, `PCPC_KEY_POWER);
        wr(`PCPC_OFF_IRQ_MASK, 8'h00);
        wr(`PCPC_OFF_POWER, 8'h02);
        rdc(`PCPC_OFF_POWER, 8'h57);
        $display("test key done");
        for (int d = 0; d < 8; d++) begin
            rnd = lfsr(rnd);
            v = (rnd[7:0] & 8'h10) | 8'(d);
            kwr(`PCPC_KEY_POWER, `PCPC_OFF_POWER, v);
            rdc(`PCPC_OFF_POWER, exp_pow(v));
            ratio(0, n);
            ratio(0, n);
            cmp(8'(n), 8'(1 << d));
            ratio(1, n);
            cmp(8'(n), 8'h05);
        end
        $display("test clocks done");
        kwr(`PCPC_KEY_POWER, `PCPC_OFF_POWER, 8'h50);
        for (int m = 0; m < 3; m++) begin
            i_mode <= pcpc_pkg::pcpc_mode_t'(m);
            wt(3);
            cmp({7'h0, o_ctl.meter_off}, {7'h0, m == 0});
            cmp({7'h0, o_ctl.core_shutdown}, {7'h0, m == 1});
        end
        i_mode <= pcpc_pkg::PCPC_MODE_NORMAL;
        kwr(`PCPC_KEY_POWER, `PCPC_OFF_POWER, 8'h02);
        $display("test modes done");
        lose <= 1'b1;
        wt(8);
        cmp(8'(n_rst), 8'h01);
        rdc(`PCPC_OFF_PERIPHERAL_SUPPLY_CONFIG, 8'h70);
        rdc(`PCPC_OFF_IRQ_STAT, 8'h05);
        cmp({7'h0, o_irq}, 8'h00);
        wr(`PCPC_OFF_IRQ_MASK, 8'h01);
        wt(2);
        cmp({7'h0, o_irq}, 8'h01);
        wr(`PCPC_OFF_ADC_START, 8'h80);
        rdc(`PCPC_OFF_PERIPHERAL_SUPPLY_CONFIG, 8'h70);
        lose <= 1'b0;
        wt(4);
        wr(`PCPC_OFF_ADC_START, 8'h80);
        rdc(`PCPC_OFF_PERIPHERAL_SUPPLY_CONFIG, 8'h60);
        rdc(`PCPC_OFF_ADC_START, 8'h00);
        wr(`PCPC_OFF_IRQ_STAT, 8'h01);
        wt(2);
        cmp({7'h0, o_irq}, 8'h00);
        $display("test lock done");
        wr(`PCPC_OFF_PERIPHERAL_SUPPLY_CONFIG, 8'h05);
        wt(2);
        cmp({3'h0, o_ctl}, 8'h05);
        i_mode <= pcpc_pkg::PCPC_MODE_SLEEP;
        i_rx_pin <= 1'b1;
        wt(6);
        rdc(`PCPC_OFF_PERIPHERAL_SUPPLY_CONFIG, 8'h65);
        wr(`PCPC_OFF_PERIPHERAL_SUPPLY_CONFIG, 8'h03);
        i_rx_pin <= 1'b0;
        wt(6);
        cmp(8'(n_wake), 8'h01);
        rdc(`PCPC_OFF_PERIPHERAL_SUPPLY_CONFIG, 8'hE3);
        rdc(`PCPC_OFF_IRQ_STAT, 8'h06);
        wr(`PCPC_OFF_PERIPHERAL_SUPPLY_CONFIG, 8'h80);
        rdc(`PCPC_OFF_PERIPHERAL_SUPPLY_CONFIG, 8'h60);
        i_mode <= pcpc_pkg::PCPC_MODE_NORMAL;
        $display("test wake done");
        kwr(`PCPC_KEY_RTC, 8'hA3, rnd[7:0]);
        wt(2);
        cmp(8'(n_rtc), 8'h01);
        wr(8'hA3, 8'h11);
        kwr(`PCPC_KEY_POWER, 8'hA4, 8'h00);
        wt(2);
        cmp(8'(n_rtc), 8'h01);
        $display("test rtc done");
        summarize();
    end
endmodule // testbench
bind pcpc_core pcpc_core_chk pcpc_core_chk_i (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .i_addr(i_addr), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_pll_locked(i_pll_locked),
    .i_mode(i_mode), .o_ctl(o_ctl), .o_mcu_reset(o_mcu_reset), .o_wake_req(o_wake_req),
    .o_rtc_wr(o_rtc_wr));
